// ==== src/serial_pin_consts.vh ====
// Purpose: Offsets, field positions, write masks and response codes for the pin and channel map block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: Offsets are local choices
`ifndef SERIAL_PIN_CONSTS_VH
`define SERIAL_PIN_CONSTS_VH
`define OFS_TX_EN0 8'h00
`define OFS_TX_EN1 8'h04
`define OFS_TX_EN2 8'h08
`define OFS_TX_EN3 8'h0c
`define OFS_PIN_CFG 8'h10
`define OFS_PORT_CTL 8'h14
`define OFS_MC_CTL 8'h18
`define OFS_RX_EN0 8'h1c
`define OFS_RX_EN1 8'h20
`define OFS_RX_EN2 8'h24
`define OFS_RX_EN3 8'h28
`define OFS_MAP_STAT 8'h2c
`define PIN_CFG_MASK 32'h0000_3f2f
`define PORT_CTL_MASK 32'h0000_001f
`define MC_CTL_MASK 32'h0000_1fff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define PC_TX_GPIO 13
`define PC_RX_GPIO 12
`define PC_TX_FRM_MODE 11
`define PC_RX_FRM_MODE 10
`define PC_TX_CLK_MODE 9
`define PC_RX_CLK_MODE 8
`define PC_EXT_CLK_LVL 6
`define PC_TX_DATA_LVL 5
`define PC_RX_DATA_LVL 4
`define PC_TX_FRM_POL 3
`define PC_RX_FRM_POL 2
`define PC_TX_CLK_POL 1
`define PC_RX_CLK_POL 0
`define PT_TX_RESET_N 0
`define PT_RX_RESET_N 1
`define PT_LOOPBACK 2
`define PT_CLK_STOP_LO 3
`define PT_CLK_STOP_HI 4
`define MC_TX_MODE_LO 0
`define MC_TX_WIDE 2
`define MC_TX_PA_LO 3
`define MC_TX_PB_LO 5
`define MC_RX_PA_LO 7
`define MC_RX_PB_LO 9
`define MC_FRAME_GEN 11
`define MC_GEN_SYNC 12
`endif

// ==== src/pin_sync3.v ====
// Purpose: Three-stage synchroniser for one pin
// Assumes: Input is asynchronous to aclk
// Notes: Output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 (
  input wire aclk,
  input wire aresetn,
  input wire pin_in,
  output reg level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/tx_chan_map.v ====
// Purpose: Maps transmit enable bits onto 128 channel flags
// Assumes: Registered inputs from the register file
// Notes: Outputs are registered, one cycle after a register change
`timescale 1ns/10ps
`default_nettype none
module tx_chan_map (
  input wire aclk,
  input wire aresetn,
  input wire [127:0] tx_en,
  input wire [127:0] rx_en,
  input wire [1:0] tx_multichannel_mode,
  input wire tx_wide_channel_select,
  input wire [1:0] tx_part_a_block,
  input wire [1:0] tx_part_b_block,
  input wire [1:0] rx_part_a_block,
  input wire [1:0] rx_part_b_block,
  output reg [127:0] chan_enable_q,
  output reg [127:0] chan_unmask_q
);
  reg [127:0] tx_map;
  reg [127:0] rx_map;
  reg [2:0] blk_a;
  reg [2:0] blk_b;
  integer i;
  always @* begin
    tx_map = 128'h0;
    rx_map = 128'h0;
    // Even and odd block picks, sources swap in symmetric mode
    if (tx_multichannel_mode == 2'h3) begin
      blk_a = {rx_part_a_block, 1'b0};
      blk_b = {rx_part_b_block, 1'b1};
    end else begin
      blk_a = {tx_part_a_block, 1'b0};
      blk_b = {tx_part_b_block, 1'b1};
    end
    for (i = 0; i < 128; i = i + 1) begin
      if (tx_wide_channel_select) begin
        tx_map[i] = tx_en[i];
        rx_map[i] = rx_en[i];
      end else if (i[6:4] == blk_a) begin
        tx_map[i] = tx_en[i[3:0]];
        rx_map[i] = rx_en[i[3:0]];
      end else if (i[6:4] == blk_b) begin
        tx_map[i] = tx_en[{1'b1, i[3:0]}];
        rx_map[i] = rx_en[{1'b1, i[3:0]}];
      end
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan_enable_q <= 128'h0;
      chan_unmask_q <= 128'h0;
    end else begin
      case (tx_multichannel_mode)
        2'h1: begin
          chan_enable_q <= tx_map;
          chan_unmask_q <= tx_map;
        end
        2'h2: begin
          chan_enable_q <= {128{1'b1}};
          chan_unmask_q <= tx_map;
        end
        2'h3: begin
          chan_enable_q <= rx_map;
          chan_unmask_q <= tx_map;
        end
        default: begin
          chan_enable_q <= {128{1'b1}};
          chan_unmask_q <= {128{1'b1}};
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== src/serial_pin_ctrl.v ====
// Purpose: Pin control and transmit channel map registers of a serial port
// Assumes: AXI4-Lite slave on aclk, pins sampled through three flip-flops
// Notes: Output enables are active low, low while driving
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "serial_pin_consts.vh"
module serial_pin_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire gen_clk,
  input wire gen_frame,
  input wire tx_frame_int,
  input wire tx_data_int,
  input wire tx_clock_pin_i,
  output reg tx_clock_pin_o,
  output reg tx_clock_pin_oe_n,
  input wire tx_frame_pin_i,
  output reg tx_frame_pin_o,
  output reg tx_frame_pin_oe_n,
  output reg tx_data_pin_o,
  output reg tx_data_pin_oe_n,
  input wire rx_clock_pin_i,
  output reg rx_clock_pin_o,
  output reg rx_clock_pin_oe_n,
  input wire rx_frame_pin_i,
  output reg rx_frame_pin_o,
  output reg rx_frame_pin_oe_n,
  input wire rx_data_pin,
  input wire ext_source_clock_pin,
  output reg tx_clk_active,
  output reg rx_clk_active,
  output reg tx_frame_active,
  output reg rx_frame_active,
  output reg rx_data_serial,
  output reg tx_frame_from_gen,
  output reg spi_master,
  output wire [127:0] chan_enable_q,
  output wire [127:0] chan_unmask_q
);
  reg [127:0] tx_en_q;
  reg [127:0] rx_en_q;
  reg [31:0] pin_cfg_q;
  reg [31:0] port_ctl_q;
  reg [31:0] mc_ctl_q;
  reg [7:0] aw_addr_q;
  reg aw_full_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_full_q;
  reg [31:0] rd_word;
  reg rd_ok;
  reg [31:0] wmask;
  wire tx_clk_s;
  wire tx_frm_s;
  wire rx_clk_s;
  wire rx_frm_s;
  wire rx_dat_s;
  wire ext_clk_s;
  // Gpio use only while that side is held in reset
  wire tx_gpio = pin_cfg_q[`PC_TX_GPIO] & ~port_ctl_q[`PT_TX_RESET_N];
  wire rx_gpio = pin_cfg_q[`PC_RX_GPIO] & ~port_ctl_q[`PT_RX_RESET_N];
  wire loopback = port_ctl_q[`PT_LOOPBACK];
  wire clk_stop = |port_ctl_q[`PT_CLK_STOP_HI:`PT_CLK_STOP_LO];
  wire do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
  // Only aligned words below the status word take writes
  wire aw_ok = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q < `OFS_MAP_STAT);
  // Transmit clock as the port sees it, pin or generator
  wire tx_clk_src = pin_cfg_q[`PC_TX_CLK_MODE] ? gen_clk : tx_clk_s;
  genvar g;

  // Every pin crosses domains, so each passes three stages first
  pin_sync3 u_sync_txc (.aclk(aclk), .aresetn(aresetn), .pin_in(tx_clock_pin_i), .level_q(tx_clk_s));
  pin_sync3 u_sync_txf (.aclk(aclk), .aresetn(aresetn), .pin_in(tx_frame_pin_i), .level_q(tx_frm_s));
  pin_sync3 u_sync_rxc (.aclk(aclk), .aresetn(aresetn), .pin_in(rx_clock_pin_i), .level_q(rx_clk_s));
  pin_sync3 u_sync_rxf (.aclk(aclk), .aresetn(aresetn), .pin_in(rx_frame_pin_i), .level_q(rx_frm_s));
  pin_sync3 u_sync_rxd (.aclk(aclk), .aresetn(aresetn), .pin_in(rx_data_pin), .level_q(rx_dat_s));
  pin_sync3 u_sync_ext (.aclk(aclk), .aresetn(aresetn), .pin_in(ext_source_clock_pin), .level_q(ext_clk_s));

  tx_chan_map u_map (
    .aclk(aclk),
    .aresetn(aresetn),
    .tx_en(tx_en_q),
    .rx_en(rx_en_q),
    .tx_multichannel_mode(mc_ctl_q[`MC_TX_MODE_LO+1:`MC_TX_MODE_LO]),
    .tx_wide_channel_select(mc_ctl_q[`MC_TX_WIDE]),
    .tx_part_a_block(mc_ctl_q[`MC_TX_PA_LO+1:`MC_TX_PA_LO]),
    .tx_part_b_block(mc_ctl_q[`MC_TX_PB_LO+1:`MC_TX_PB_LO]),
    .rx_part_a_block(mc_ctl_q[`MC_RX_PA_LO+1:`MC_RX_PA_LO]),
    .rx_part_b_block(mc_ctl_q[`MC_RX_PB_LO+1:`MC_RX_PB_LO]),
    .chan_enable_q(chan_enable_q),
    .chan_unmask_q(chan_unmask_q)
  );

  // Address and data held until both present; response after both
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;
  // One read at a time; a new address waits out rready
  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 8'h00;
      aw_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      w_full_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_addr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_ok) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; channel enable arrays share one generate loop
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_en
      always @(posedge aclk) begin
        if (!aresetn) begin
          tx_en_q[32*g+31:32*g] <= 32'h0000_0000;
          rx_en_q[32*g+31:32*g] <= 32'h0000_0000;
        end else if (do_write) begin
          if (aw_addr_q == `OFS_TX_EN0 + 8'h04 * g) begin
            tx_en_q[32*g+31:32*g] <= (tx_en_q[32*g+31:32*g] & ~wmask) | (w_data_q & wmask);
          end else if (aw_addr_q == `OFS_RX_EN0 + 8'h04 * g) begin
            rx_en_q[32*g+31:32*g] <= (rx_en_q[32*g+31:32*g] & ~wmask) | (w_data_q & wmask);
          end
        end
      end
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_cfg_q <= 32'h0000_0000;
      port_ctl_q <= 32'h0000_0000;
      mc_ctl_q <= 32'h0000_0000;
    end else if (do_write) begin
      if (aw_addr_q == `OFS_PIN_CFG) begin
        // Bit 7 and 31-14 never stored, so a stray one is harmless
        pin_cfg_q <= (pin_cfg_q & ~(wmask & `PIN_CFG_MASK)) | (w_data_q & wmask & `PIN_CFG_MASK);
      end else if (aw_addr_q == `OFS_PORT_CTL) begin
        port_ctl_q <= (port_ctl_q & ~(wmask & `PORT_CTL_MASK)) | (w_data_q & wmask & `PORT_CTL_MASK);
      end else if (aw_addr_q == `OFS_MC_CTL) begin
        mc_ctl_q <= (mc_ctl_q & ~(wmask & `MC_CTL_MASK)) | (w_data_q & wmask & `MC_CTL_MASK);
      end
    end
  end

  // Read decode; status bits are live synchronised pin levels while the rx side is in gpio use, else 0
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == `OFS_PIN_CFG) begin
      rd_word = pin_cfg_q;
      rd_word[`PC_EXT_CLK_LVL] = rx_gpio & ext_clk_s;
      rd_word[`PC_RX_DATA_LVL] = rx_gpio & rx_dat_s;
    end else if (s_axi_araddr == `OFS_PORT_CTL) begin
      rd_word = port_ctl_q;
    end else if (s_axi_araddr == `OFS_MC_CTL) begin
      rd_word = mc_ctl_q;
    end else if (s_axi_araddr == `OFS_TX_EN0) begin
      rd_word = tx_en_q[31:0];
    end else if (s_axi_araddr == `OFS_TX_EN1) begin
      rd_word = tx_en_q[63:32];
    end else if (s_axi_araddr == `OFS_TX_EN2) begin
      rd_word = tx_en_q[95:64];
    end else if (s_axi_araddr == `OFS_TX_EN3) begin
      rd_word = tx_en_q[127:96];
    end else if (s_axi_araddr == `OFS_RX_EN0) begin
      rd_word = rx_en_q[31:0];
    end else if (s_axi_araddr == `OFS_RX_EN1) begin
      rd_word = rx_en_q[63:32];
    end else if (s_axi_araddr == `OFS_RX_EN2) begin
      rd_word = rx_en_q[95:64];
    end else if (s_axi_araddr == `OFS_RX_EN3) begin
      rd_word = rx_en_q[127:96];
    end else if (s_axi_araddr == `OFS_MAP_STAT) begin
      rd_word = {30'h0000_0000, tx_gpio, rx_gpio};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pin steering; registered so pins see no decode glitches
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_clock_pin_o <= 1'b0;
      tx_clock_pin_oe_n <= 1'b1;
      tx_frame_pin_o <= 1'b0;
      tx_frame_pin_oe_n <= 1'b1;
      tx_data_pin_o <= 1'b0;
      tx_data_pin_oe_n <= 1'b1;
      rx_clock_pin_o <= 1'b0;
      rx_clock_pin_oe_n <= 1'b1;
      rx_frame_pin_o <= 1'b0;
      rx_frame_pin_oe_n <= 1'b1;
      tx_clk_active <= 1'b0;
      rx_clk_active <= 1'b0;
      tx_frame_active <= 1'b0;
      rx_frame_active <= 1'b0;
      rx_data_serial <= 1'b0;
      tx_frame_from_gen <= 1'b0;
      spi_master <= 1'b0;
    end else begin
      spi_master <= clk_stop & pin_cfg_q[`PC_TX_CLK_MODE];
      tx_frame_from_gen <= pin_cfg_q[`PC_TX_FRM_MODE] & mc_ctl_q[`MC_FRAME_GEN];
      if (tx_gpio) begin
        // Gpio direction follows the mode bits; data pin only drives
        tx_data_pin_o <= pin_cfg_q[`PC_TX_DATA_LVL];
        tx_data_pin_oe_n <= 1'b0;
        tx_clock_pin_oe_n <= ~pin_cfg_q[`PC_TX_CLK_MODE];
        tx_clock_pin_o <= pin_cfg_q[`PC_TX_CLK_POL];
        tx_frame_pin_oe_n <= ~pin_cfg_q[`PC_TX_FRM_MODE];
        tx_frame_pin_o <= pin_cfg_q[`PC_TX_FRM_POL];
        tx_clk_active <= 1'b0;
        tx_frame_active <= 1'b0;
      end else begin
        tx_data_pin_o <= tx_data_int;
        tx_data_pin_oe_n <= 1'b0;
        tx_clock_pin_oe_n <= ~pin_cfg_q[`PC_TX_CLK_MODE];
        tx_clock_pin_o <= gen_clk;
        // Active level of tx clock edge, folded with polarity
        tx_clk_active <= (pin_cfg_q[`PC_TX_CLK_MODE] ? gen_clk : tx_clk_s) ^ pin_cfg_q[`PC_TX_CLK_POL];
        tx_frame_pin_oe_n <= ~pin_cfg_q[`PC_TX_FRM_MODE];
        tx_frame_pin_o <= (pin_cfg_q[`PC_TX_FRM_MODE] ? (mc_ctl_q[`MC_FRAME_GEN] ? gen_frame : tx_frame_int) : 1'b0)
          ^ pin_cfg_q[`PC_TX_FRM_POL];
        tx_frame_active <= (pin_cfg_q[`PC_TX_FRM_MODE] ? (mc_ctl_q[`MC_FRAME_GEN] ? gen_frame : tx_frame_int)
          : (tx_frm_s ^ pin_cfg_q[`PC_TX_FRM_POL]));
      end
      if (rx_gpio) begin
        rx_clock_pin_oe_n <= ~pin_cfg_q[`PC_RX_CLK_MODE];
        rx_clock_pin_o <= pin_cfg_q[`PC_RX_CLK_POL];
        rx_frame_pin_oe_n <= ~pin_cfg_q[`PC_RX_FRM_MODE];
        rx_frame_pin_o <= pin_cfg_q[`PC_RX_FRM_POL];
        // Gpio pins carry no serial clock, frame or data
        rx_clk_active <= 1'b0;
        rx_frame_active <= 1'b0;
        rx_data_serial <= 1'b0;
      end else begin
        rx_data_serial <= rx_dat_s;
        // Pin direction follows bit 8 in every mode; spi only reroutes the clock
        rx_clock_pin_oe_n <= ~pin_cfg_q[`PC_RX_CLK_MODE];
        if (loopback) begin
          // Loopback wins over spi; both take the transmit clock
          rx_clock_pin_o <= tx_clk_src;
          rx_clk_active <= tx_clk_src ^ ~pin_cfg_q[`PC_RX_CLK_POL];
        end else if (clk_stop) begin
          // Spi: receive clock follows transmit clock in either role
          rx_clock_pin_o <= gen_clk;
          rx_clk_active <= tx_clk_src ^ ~pin_cfg_q[`PC_RX_CLK_POL];
        end else begin
          rx_clock_pin_o <= gen_clk;
          // Falling edge sampling by default, so invert when bit is 0
          rx_clk_active <= (pin_cfg_q[`PC_RX_CLK_MODE] ? gen_clk : rx_clk_s) ^ ~pin_cfg_q[`PC_RX_CLK_POL];
        end
        rx_frame_pin_oe_n <= ~(pin_cfg_q[`PC_RX_FRM_MODE] & ~mc_ctl_q[`MC_GEN_SYNC]);
        rx_frame_pin_o <= gen_frame ^ pin_cfg_q[`PC_RX_FRM_POL];
        rx_frame_active <= (pin_cfg_q[`PC_RX_FRM_MODE] ? gen_frame : (rx_frm_s ^ pin_cfg_q[`PC_RX_FRM_POL]));
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/serial_pin_ctrl_asserts.sv ====
// Purpose: Concurrent checks on pin direction, gpio drive and readback
// Assumes: Full-strobe writes; shadow copies follow answered writes
// Notes: Pin checks wait three quiet edges, since pins lag the register
`timescale 1ns/10ps
`default_nettype none
`include "serial_pin_consts.vh"
module serial_pin_ctrl_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic tx_clock_pin_oe_n,
  input wire logic tx_frame_pin_oe_n,
  input wire logic tx_data_pin_o,
  input wire logic tx_data_pin_oe_n,
  input wire logic rx_clock_pin_oe_n,
  input wire logic rx_frame_pin_oe_n,
  input wire logic rx_frame_pin_i,
  input wire logic rx_frame_active,
  input wire logic spi_master,
  input wire logic tx_clk_active,
  input wire logic rx_data_serial
);
  logic [7:0] aw_q, ar_q;
  logic [31:0] w_q, pc_q, pt_q;
  logic [1:0] quiet_q;
  wire txg = pc_q[13] & ~pt_q[0];
  wire rxg = pc_q[12] & ~pt_q[1];
  wire calm = quiet_q == 2'h3;
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    if (!aresetn) begin
      pc_q <= 32'h0;
      pt_q <= 32'h0;
      quiet_q <= 2'h0;
    end else if ($rose(s_axi_bvalid) && s_axi_bresp == `RESP_OKAY) begin
      quiet_q <= 2'h0;
      if (aw_q == `OFS_PIN_CFG) pc_q <= w_q & `PIN_CFG_MASK;
      if (aw_q == `OFS_PORT_CTL) pt_q <= w_q;
    end else if (!calm) quiet_q <= quiet_q + 2'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rx_pin_in;
    calm && !rxg && !pt_q[2] && !pc_q[10];
  endsequence
  sequence s_frame_rise;
    $rose(rx_frame_pin_i) ##0 s_rx_pin_in;
  endsequence
  a_tx_clk_dir: assert property (calm && !txg |-> tx_clock_pin_oe_n == !pc_q[9])
    else $error("tx clock pin direction");
  a_rx_clk_dir: assert property (calm && !rxg |-> rx_clock_pin_oe_n == !pc_q[8])
    else $error("rx clock pin direction");
  a_rx_frame_in: assert property (s_rx_pin_in |-> rx_frame_pin_oe_n)
    else $error("rx frame pin driven");
  a_tx_frame_in: assert property (calm && !txg && !pc_q[11] |-> tx_frame_pin_oe_n)
    else $error("tx frame pin driven");
  a_gpio_data_out: assert property (calm && txg |-> !tx_data_pin_oe_n && tx_data_pin_o == pc_q[5])
    else $error("tx data gpio level");
  a_spi_role: assert property (calm |-> spi_master == (pt_q[4:3] != 2'h0 && pc_q[9]))
    else $error("spi role");
  a_rx_frame_pol: assert property (s_frame_rise |-> ##[1:6] rx_frame_active == !pc_q[2])
    else $error("rx frame polarity");
  a_pin_read_zero: assert property (s_axi_rvalid && ar_q == `OFS_PIN_CFG |-> s_axi_rdata[31:14] == 18'h0 && !s_axi_rdata[7])
    else $error("pin config reserved bits");
  a_tx_gpio_idle: assert property (calm && txg |-> !tx_clk_active)
    else $error("tx clock active in gpio");
  a_rx_gpio_idle: assert property (calm && rxg |-> !rx_data_serial)
    else $error("rx data passed in gpio");
endmodule
bind serial_pin_ctrl serial_pin_ctrl_asserts chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .tx_clock_pin_oe_n, .tx_frame_pin_oe_n, .tx_data_pin_o,
  .tx_data_pin_oe_n, .rx_clock_pin_oe_n, .rx_frame_pin_oe_n, .rx_frame_pin_i, .rx_frame_active, .spi_master,
  .tx_clk_active, .rx_data_serial);
`default_nettype wire

// ==== testbench/serial_peer.sv ====
// Purpose: Codec side of the link: clock, frame, data, source clock
// Assumes: Active-high frames of eight bits, 800 ns bit time
// Notes: Clock stands still between frames; idle data inverts
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  output var logic link_clk,
  output var logic frame,
  output var logic data,
  output var logic ext_clk
);
  initial begin
    link_clk = 1'b0;
    frame = 1'b0;
    data = 1'b0;
    ext_clk = 1'b0;
    forever begin
      #1600;
      frame = 1'b1;
      repeat (8) begin
        data = 1'($urandom);
        #400;
        link_clk = 1'b1;
        #400;
        link_clk = 1'b0;
        frame = 1'b0;
      end
      data = ~data;
      ext_clk = ~ext_clk;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_serial_pin_ctrl.sv ====
// Purpose: Self-checking bench for pin control and transmit channel map
// Assumes: AXI4-Lite master with full strobes, codec model on the pins
// Notes: Map checks cover every mode in both widths with random blocks
`timescale 1ns/10ps
`default_nettype none
`include "serial_pin_consts.vh"
module test_serial_pin_ctrl;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic gen_clk, gen_frame, tx_frame_int, tx_data_int;
  wire tx_clock_pin_o, tx_clock_pin_oe_n, tx_frame_pin_o, tx_frame_pin_oe_n;
  wire rx_clock_pin_o, rx_clock_pin_oe_n, rx_frame_pin_o, rx_frame_pin_oe_n;
  wire lclk, lfrm, rx_data_pin, ext_source_clock_pin;
  wire [127:0] chan_enable_q, chan_unmask_q;
  // Wire level resolved from the design's enable; peer drives when released
  wire tx_clock_pin_i = tx_clock_pin_oe_n ? lclk : tx_clock_pin_o;
  wire tx_frame_pin_i = tx_frame_pin_oe_n ? lfrm : tx_frame_pin_o;
  wire rx_clock_pin_i = rx_clock_pin_oe_n ? lclk : rx_clock_pin_o;
  wire rx_frame_pin_i = rx_frame_pin_oe_n ? lfrm : rx_frame_pin_o;
  int mismatches, n_tests;
  logic [127:0] tx_v, rx_v, ee, eu;
  serial_peer peer (.link_clk(lclk), .frame(lfrm), .data(rx_data_pin), .ext_clk(ext_source_clock_pin));
  serial_pin_ctrl uut (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .tx_data_pin_o(), .tx_data_pin_oe_n(),
    .tx_clk_active(), .rx_clk_active(), .tx_frame_active(), .rx_frame_active(), .rx_data_serial(),
    .tx_frame_from_gen(), .spi_master());
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({126'h0, s_axi_bresp}, {126'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic [33:0] got;
    got = 34'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    got = {s_axi_rresp, s_axi_rdata & m};
    s_axi_rready <= 1'b0;
    chk({94'h0, got}, {94'h0, er, e});
  endtask
  function automatic logic [127:0] fmap(input logic [127:0] v, input logic w, input logic [1:0] a, input logic [1:0] b);
    fmap = w ? v : 128'h0;
    if (!w) begin
      fmap[32*a +: 16] = v[15:0];
      fmap[32*b+16 +: 16] = v[31:16];
    end
  endfunction
  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) {gen_clk, gen_frame, tx_frame_int, tx_data_int} <= 4'($urandom);
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
  initial begin
    logic [31:0] pc, mc;
    mismatches = 0;
    n_tests = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'hf270));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'(4*i), 32'hffffffff, 32'h0, `RESP_OKAY);
    wr(`OFS_PIN_CFG, 32'hffffff7f, `RESP_OKAY);
    rd(`OFS_PIN_CFG, 32'hffffffaf, 32'h3f2f, `RESP_OKAY);
    // Both sides held in reset, so the status bits show live pins
    for (int i = 0; i < 2; i++) begin
      @(posedge lfrm);
      rd(`OFS_PIN_CFG, 32'h40, {25'h0, ext_source_clock_pin, 6'h0}, `RESP_OKAY);
      @(posedge lclk);
      rd(`OFS_PIN_CFG, 32'h10, {27'h0, rx_data_pin, 4'h0}, `RESP_OKAY);
    end
    for (int i = 0; i < 24; i++) begin
      // Reconfigure just after the frame pulse falls, so no frame check straddles a change
      @(negedge lfrm);
      pc = $urandom & 32'hffffff7f;
      wr(`OFS_PORT_CTL, $urandom & 32'h1f, `RESP_OKAY);
      wr(`OFS_PIN_CFG, pc, `RESP_OKAY);
      rd(`OFS_PIN_CFG, 32'hffffffaf, pc & 32'h3f2f, `RESP_OKAY);
      repeat (90) @(posedge aclk);
    end
    for (int i = 0; i < 4; i++) begin
      tx_v[32*i +: 32] = $urandom;
      rx_v[32*i +: 32] = $urandom;
      wr(8'(4*i), tx_v[32*i +: 32], `RESP_OKAY);
      wr(8'(28+4*i), rx_v[32*i +: 32], `RESP_OKAY);
      rd(8'(4*i), 32'hffffffff, tx_v[32*i +: 32], `RESP_OKAY);
    end
    for (int i = 0; i < 16; i++) begin
      mc = ($urandom & 32'h7f8) | 32'(i & 7);
      wr(`OFS_MC_CTL, mc, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      eu = fmap(tx_v, mc[2], mc[1:0] == 2'h3 ? mc[8:7] : mc[4:3], mc[1:0] == 2'h3 ? mc[10:9] : mc[6:5]);
      ee = fmap(rx_v, mc[2], mc[8:7], mc[10:9]);
      case (mc[1:0])
        2'h0: begin
          ee = '1;
          eu = '1;
        end
        2'h1: ee = eu;
        2'h2: ee = '1;
        default: ;
      endcase
      chk(chan_enable_q, ee);
      chk(chan_unmask_q, eu);
    end
    wr(8'h30, 32'h1, `RESP_SLVERR);
    rd(8'h30, 32'hffffffff, 32'h0, `RESP_SLVERR);
    wr(`OFS_MAP_STAT, 32'h3, `RESP_SLVERR);
    conclude();
  end
endmodule
`default_nettype wire
